// *** src/rcn_pkg.sv ***
// package of constants and carrier types for the reconnection supervisor
package rcn_pkg;
    localparam int RCN_NUM_UNITS = 2;
    localparam int RCN_NUM_DECOUPLE = 6;
    localparam int RCN_MEAS_W = 16;
    localparam int RCN_TIMER_W = 32;
    localparam int RCN_CLK_MHZ = 200;
    // one tick of the settle timer, in microseconds
    localparam int RCN_TICK_US = 1;
    localparam int RCN_TICK_CYCLES = RCN_TICK_US * RCN_CLK_MHZ;
    localparam logic [RCN_TIMER_W-1:0] RCN_SETTLE_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        RCN_IDLE,
        RCN_EVAL,
        RCN_RELEASED
    } rcn_state_type;

    // per-unit settings, static from the configuration side
    typedef struct packed {
        logic enable;
        logic use_breaker;
        logic [RCN_NUM_DECOUPLE-1:0] decouple_assign;
        logic use_fuse_block;
        logic check_voltage;
        logic check_freq;
        logic check_ext_release;
        logic trig_on_ext_fall;
        logic [RCN_MEAS_W-1:0] v_min;
        logic [RCN_MEAS_W-1:0] v_max;
        logic [RCN_MEAS_W-1:0] f_min;
        logic [RCN_MEAS_W-1:0] f_max;
        logic [RCN_MEAS_W-1:0] v_freq_block;
        logic [RCN_TIMER_W-1:0] settle_ticks;
    } rcn_cfg_type;

    // per-unit pin inputs
    typedef struct packed {
        logic breaker_closed;
        logic [RCN_NUM_DECOUPLE-1:0] decouple;
        logic external_voltage_release;
        logic vt_fuse_failure_input;
        logic external_block_input;
    } rcn_pins_type;

    typedef struct packed {
        logic [RCN_MEAS_W-1:0] voltage;
        logic [RCN_MEAS_W-1:0] freq;
    } rcn_meas_type;
endpackage

// *** src/rcn_sync.sv ***
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module rcn_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            meta_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule

// *** src/rcn_unit.sv ***
// one reconnection unit: trigger logic, release checks, settle timer
`timescale 1ns/1ps
module rcn_unit (
    input wire logic mclk,
    input wire logic reset,
    input wire logic tick,
    input rcn_pkg::rcn_cfg_type cfg,
    input rcn_pkg::rcn_pins_type pins,
    input rcn_pkg::rcn_meas_type meas,
    input wire logic peer_block,
    output logic evaluating,
    output logic permit,
    output logic trig_pulse
);
    import rcn_pkg::*;

    rcn_state_type state_r;
    logic [RCN_TIMER_W-1:0] timer_r;
    logic brk_prev_r;
    logic ext_prev_r;
    logic [RCN_NUM_DECOUPLE-1:0] dec_prev_r;
    logic [RCN_NUM_DECOUPLE-1:0] dec_act;
    logic any_dec;
    logic dec_rise;
    logic brk_fall;
    logic brk_rise;
    logic ext_fall;
    logic blocked;
    logic f_blocked;
    logic v_ok;
    logic f_ok;
    logic x_ok;
    logic cond_ok;
    logic use_dec;
    logic trigger;
    logic drop;

    assign dec_act = pins.decouple & cfg.decouple_assign;
    assign use_dec = |cfg.decouple_assign;
    assign any_dec = |dec_act;
    assign dec_rise = |(dec_act & ~dec_prev_r);
    assign brk_fall = cfg.use_breaker & brk_prev_r & ~pins.breaker_closed;
    assign brk_rise = cfg.use_breaker & ~brk_prev_r & pins.breaker_closed;
    assign ext_fall = ext_prev_r & ~pins.external_voltage_release;

    // instance off, external block, peer block or fuse failure
    assign blocked = ~cfg.enable | pins.external_block_input | peer_block
        | (cfg.use_fuse_block & pins.vt_fuse_failure_input);
    // frequency checks only valid at or above the blocking voltage
    assign f_blocked = meas.voltage < cfg.v_freq_block;
    assign v_ok = ~cfg.check_voltage
        | (meas.voltage >= cfg.v_min && meas.voltage <= cfg.v_max);
    assign f_ok = ~cfg.check_freq | (~f_blocked
        && meas.freq >= cfg.f_min && meas.freq <= cfg.f_max);
    assign x_ok = ~cfg.check_ext_release | pins.external_voltage_release;
    assign cond_ok = ~any_dec & v_ok & f_ok & x_ok;

    always_comb
    begin
        if (cfg.use_breaker && use_dec)
            trigger = brk_fall & any_dec;
        else if (cfg.use_breaker)
            trigger = brk_fall;
        else if (use_dec)
            trigger = dec_rise;
        else
            trigger = ~(v_ok & f_ok & x_ok);
        if (cfg.trig_on_ext_fall && ext_fall)
            trigger = 1'b1;
    end

    // permit withdrawal: breaker closing, new decoupling, lost condition
    assign drop = brk_rise | (use_dec & dec_rise) | ~cond_ok;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            brk_prev_r <= 1'b0;
            ext_prev_r <= 1'b0;
            dec_prev_r <= '0;
        end
        else
        begin
            brk_prev_r <= pins.breaker_closed;
            ext_prev_r <= pins.external_voltage_release;
            dec_prev_r <= dec_act;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_r <= RCN_IDLE;
            timer_r <= RCN_SETTLE_RESET;
        end
        else if (blocked)
        begin
            state_r <= RCN_IDLE;
            timer_r <= RCN_SETTLE_RESET;
        end
        else
        begin
            case (state_r)
                RCN_IDLE:
                begin
                    timer_r <= RCN_SETTLE_RESET;
                    if (trigger)
                        state_r <= RCN_EVAL;
                end
                RCN_EVAL:
                begin
                    if (!cond_ok)
                        timer_r <= RCN_SETTLE_RESET;
                    else if (timer_r >= cfg.settle_ticks)
                        state_r <= RCN_RELEASED;
                    else if (tick)
                        timer_r <= timer_r + 32'h1;
                end
                RCN_RELEASED:
                begin
                    timer_r <= RCN_SETTLE_RESET;
                    if (drop)
                        state_r <= trigger ? RCN_EVAL : RCN_IDLE;
                end
                default:
                    state_r <= RCN_IDLE;
            endcase
        end
    end

    assign evaluating = (state_r == RCN_EVAL);
    assign permit = (state_r == RCN_RELEASED);
    assign trig_pulse = ~blocked & trigger & (state_r == RCN_IDLE);

    sequence s_lapse;
        (state_r == RCN_EVAL) && !cond_ok;
    endsequence

    sequence s_settled;
        !blocked && (state_r == RCN_EVAL) && cond_ok
            && timer_r >= cfg.settle_ticks;
    endsequence

    property p_settle;
        @(posedge mclk) disable iff (reset)
        s_lapse |=> timer_r == RCN_SETTLE_RESET;
    endproperty
    a_settle: assert property (p_settle)
        else $error("settle timer not cleared on lapse");

    property p_block;
        @(posedge mclk) disable iff (reset)
        blocked |=> !evaluating && !permit;
    endproperty
    a_block: assert property (p_block)
        else $error("blocked unit still active");

    property p_release;
        @(posedge mclk) disable iff (reset)
        s_settled |=> permit && !evaluating;
    endproperty
    a_release: assert property (p_release)
        else $error("settled unit gave no permit");

    property p_drop;
        @(posedge mclk) disable iff (reset)
        permit && drop |=> !permit;
    endproperty
    a_drop: assert property (p_drop)
        else $error("permit held after drop condition");
endmodule

// *** src/rcn_top.sv ***
// reconnection supervisor with two units, registers and interrupt
//
// Contract
// - two reconnection units, independent unless unit 1 is chained behind unit 0
// - conditions met, settle timer, then permit
// - evaluating flag until permit asserted
// - deactivated or externally blocked unit is idle
// - fuse failure blocks unit when configured
// - six decoupling trigger inputs per unit
// - low voltage blocks frequency checks
// - triggers: breaker open, decoupling, limits, release
// - release: no decoupling, limits, external release
// - both assigned: breaker falls during decoupling
// - both assigned: drop on close, trip, fail
// - breaker only: trigger on fall, drop similarly
// - decoupling only: trigger on decoupling rise
// - none assigned: trigger on condition failure
`timescale 1ns/1ps
module rcn_top (
    input wire logic mclk,
    input wire logic reset,
    input rcn_pkg::rcn_pins_type pins0,
    input rcn_pkg::rcn_pins_type pins1,
    input rcn_pkg::rcn_meas_type meas,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    import rcn_pkg::*;

    localparam logic [3:0] A_CTRL0 = 4'h0;
    localparam logic [3:0] A_CTRL1 = 4'h1;
    localparam logic [3:0] A_VLIM0 = 4'h2;
    localparam logic [3:0] A_VLIM1 = 4'h3;
    localparam logic [3:0] A_FLIM0 = 4'h4;
    localparam logic [3:0] A_FLIM1 = 4'h5;
    localparam logic [3:0] A_VFB = 4'h6;
    localparam logic [3:0] A_SET0 = 4'h7;
    localparam logic [3:0] A_SET1 = 4'h8;
    localparam logic [3:0] A_STAT = 4'h9;
    localparam logic [3:0] A_ISTAT = 4'ha;
    localparam logic [3:0] A_IMASK = 4'hb;

    rcn_cfg_type cfg_r [RCN_NUM_UNITS];
    logic [RCN_MEAS_W-1:0] vfb_r;
    logic chain_r;
    logic [5:0] ist_r;
    logic [5:0] imask_r;
    logic [7:0] tick_cnt_r;
    logic tick;
    rcn_pins_type pins_s [RCN_NUM_UNITS];
    rcn_pins_type pins_raw [RCN_NUM_UNITS];
    rcn_meas_type meas_r;
    logic [RCN_NUM_UNITS-1:0] eval_w;
    logic [RCN_NUM_UNITS-1:0] perm_w;
    logic [RCN_NUM_UNITS-1:0] trig_w;
    logic [RCN_NUM_UNITS-1:0] perm_prev_r;
    logic [5:0] ev;

    assign pins_raw[0] = pins0;
    assign pins_raw[1] = pins1;

    // settle timer time base
    always_ff @(posedge mclk)
    begin
        if (reset || tick)
            tick_cnt_r <= 8'h00;
        else
            tick_cnt_r <= tick_cnt_r + 8'h01;
    end
    assign tick = tick_cnt_r == 8'(RCN_TICK_CYCLES - 1);

    // measurement words come from same-clock logic
    always_ff @(posedge mclk)
    begin
        if (reset)
            meas_r <= '0;
        else
            meas_r <= meas;
    end

    generate
        for (genvar u = 0; u < RCN_NUM_UNITS; u++)
        begin : g_unit
            rcn_cfg_type ucfg;
            rcn_sync #(.W($bits(rcn_pins_type))) u_sync (
                .mclk(mclk),
                .reset(reset),
                .async_in(pins_raw[u]),
                .sync_out(pins_s[u])
            );
            always_comb
            begin
                ucfg = cfg_r[u];
                ucfg.v_freq_block = vfb_r;
            end
            rcn_unit u_unit (
                .mclk(mclk),
                .reset(reset),
                .tick(tick),
                .cfg(ucfg),
                .pins(pins_s[u]),
                .meas(meas_r),
                // optional chaining of unit 1 behind unit 0
                .peer_block((u == 1) ? (chain_r & eval_w[0]) : 1'b0),
                .evaluating(eval_w[u]),
                .permit(perm_w[u]),
                .trig_pulse(trig_w[u])
            );
        end
    endgenerate

    // register writes; control word: enable, breaker, fuse, checks, assign
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            for (int i = 0; i < RCN_NUM_UNITS; i++)
                cfg_r[i] <= '0;
            vfb_r <= '0;
            chain_r <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == A_CTRL0 || reg_addr == A_CTRL1)
            begin
                cfg_r[reg_addr[0]].enable <= reg_wdata[0];
                cfg_r[reg_addr[0]].use_breaker <= reg_wdata[1];
                cfg_r[reg_addr[0]].use_fuse_block <= reg_wdata[2];
                cfg_r[reg_addr[0]].check_voltage <= reg_wdata[3];
                cfg_r[reg_addr[0]].check_freq <= reg_wdata[4];
                cfg_r[reg_addr[0]].check_ext_release <= reg_wdata[5];
                cfg_r[reg_addr[0]].trig_on_ext_fall <= reg_wdata[6];
                cfg_r[reg_addr[0]].decouple_assign <= reg_wdata[13:8];
                if (reg_addr == A_CTRL1)
                    chain_r <= reg_wdata[16];
            end
            else if (reg_addr == A_VLIM0 || reg_addr == A_VLIM1)
            begin
                cfg_r[reg_addr == A_VLIM1].v_min <= reg_wdata[15:0];
                cfg_r[reg_addr == A_VLIM1].v_max <= reg_wdata[31:16];
            end
            else if (reg_addr == A_FLIM0 || reg_addr == A_FLIM1)
            begin
                cfg_r[reg_addr == A_FLIM1].f_min <= reg_wdata[15:0];
                cfg_r[reg_addr == A_FLIM1].f_max <= reg_wdata[31:16];
            end
            else if (reg_addr == A_VFB)
                vfb_r <= reg_wdata[15:0];
            else if (reg_addr == A_SET0)
                cfg_r[0].settle_ticks <= reg_wdata;
            else if (reg_addr == A_SET1)
                cfg_r[1].settle_ticks <= reg_wdata;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            imask_r <= '0;
        else if (reg_wr && reg_addr == A_IMASK)
            imask_r <= reg_wdata[5:0];
    end

    // events: trigger, permit rise, permit fall per unit
    always_ff @(posedge mclk)
    begin
        if (reset)
            perm_prev_r <= '0;
        else
            perm_prev_r <= perm_w;
    end
    assign ev = {perm_prev_r & ~perm_w, perm_w & ~perm_prev_r, trig_w};

    // set wins over write-one-to-clear
    always_ff @(posedge mclk)
    begin
        if (reset)
            ist_r <= '0;
        else if (reg_wr && reg_addr == A_ISTAT)
            ist_r <= (ist_r & ~reg_wdata[5:0]) | ev;
        else
            ist_r <= ist_r | ev;
    end

    assign irq = |(ist_r & imask_r);

    always_ff @(posedge mclk)
    begin
        if (reset)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            if (reg_addr == A_CTRL0 || reg_addr == A_CTRL1)
                reg_rdata <= {15'h0, (reg_addr == A_CTRL1) & chain_r,
                    2'h0, cfg_r[reg_addr[0]].decouple_assign, 1'b0,
                    cfg_r[reg_addr[0]].trig_on_ext_fall,
                    cfg_r[reg_addr[0]].check_ext_release,
                    cfg_r[reg_addr[0]].check_freq,
                    cfg_r[reg_addr[0]].check_voltage,
                    cfg_r[reg_addr[0]].use_fuse_block,
                    cfg_r[reg_addr[0]].use_breaker,
                    cfg_r[reg_addr[0]].enable};
            else if (reg_addr == A_VLIM0 || reg_addr == A_VLIM1)
                reg_rdata <= {cfg_r[reg_addr == A_VLIM1].v_max,
                    cfg_r[reg_addr == A_VLIM1].v_min};
            else if (reg_addr == A_FLIM0 || reg_addr == A_FLIM1)
                reg_rdata <= {cfg_r[reg_addr == A_FLIM1].f_max,
                    cfg_r[reg_addr == A_FLIM1].f_min};
            else if (reg_addr == A_VFB)
                reg_rdata <= {16'h0, vfb_r};
            else if (reg_addr == A_SET0)
                reg_rdata <= cfg_r[0].settle_ticks;
            else if (reg_addr == A_SET1)
                reg_rdata <= cfg_r[1].settle_ticks;
            else if (reg_addr == A_STAT)
                reg_rdata <= {28'h0, perm_w, eval_w};
            else if (reg_addr == A_ISTAT)
                reg_rdata <= {26'h0, ist_r};
            else if (reg_addr == A_IMASK)
                reg_rdata <= {26'h0, imask_r};
            else
                reg_rdata <= '0;
        end
    end

    property p_chain;
        @(posedge mclk) disable iff (reset)
        chain_r && eval_w[0] |=> !perm_w[1];
    endproperty
    a_chain: assert property (p_chain)
        else $error("second unit released while first evaluates");

    property p_eval_clear;
        @(posedge mclk) disable iff (reset)
        $rose(perm_w[0]) |-> !eval_w[0] && $past(eval_w[0]);
    endproperty
    a_eval_clear: assert property (p_eval_clear)
        else $error("unit 0 permit without evaluation before it");

    // a mask write in the same cycle may legally hide the event
    property p_irq;
        @(posedge mclk) disable iff (reset)
        |(ev & imask_r) && !(reg_wr && reg_addr == A_IMASK) |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("masked-in event gave no interrupt");
endmodule

// *** tb/rcn_field.sv ***
// behavioural breaker contacts and decoupling relays for one unit
`timescale 1ns/1ps
module rcn_field #(
    parameter int MECH_DLY = 20
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic brk_cmd,
    input wire logic [5:0] trip_req,
    input wire logic ext_rel,
    input wire logic fuse,
    input wire logic blk,
    output rcn_pkg::rcn_pins_type pins
);
    import rcn_pkg::*;
    int cnt_r;
    logic closed_r;
    logic [3:0] pos_r;
    logic [5:0] hold_r;
    // contacts move only after the mechanism delay
    always_ff @(posedge mclk)
    begin
        if (reset || brk_cmd == closed_r)
            cnt_r <= 0;
        else
            cnt_r <= cnt_r + 1;
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
            closed_r <= 1'b1;
        else if (cnt_r == MECH_DLY)
            closed_r <= brk_cmd;
    end
    always_ff @(posedge mclk)
    begin
        if (reset)
            pos_r <= 4'hf;
        else
            pos_r <= {pos_r[2:0], closed_r};
    end
    // a trip stays up until the contacts have been open a few cycles
    always_ff @(posedge mclk)
    begin
        if (reset || pos_r == 4'h0)
            hold_r <= 6'h00;
        else
            hold_r <= hold_r | trip_req;
    end
    assign pins.breaker_closed = closed_r;
    assign pins.decouple = trip_req | hold_r;
    assign pins.external_voltage_release = ext_rel;
    assign pins.vt_fuse_failure_input = fuse;
    assign pins.external_block_input = blk;
endmodule

// *** tb/rcn_top_tb.sv ***
// self-checking bench for the reconnection supervisor
`timescale 1ns/1ps
module rcn_top_tb;
    import rcn_pkg::*;
    localparam logic [31:0] EN = 32'h1;
    localparam logic [31:0] BRK = 32'h2;
    localparam logic [31:0] FUS = 32'h4;
    localparam logic [31:0] CV = 32'h8;
    localparam logic [31:0] CF = 32'h10;
    localparam logic [31:0] CX = 32'h20;
    logic mclk;
    logic reset;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic irq;
    rcn_meas_type meas;
    rcn_pins_type pins [2];
    logic [1:0] brk_cmd;
    logic [1:0] ext_rel;
    logic [1:0] fuse;
    logic [1:0] blk;
    logic [5:0] trip [2];
    int error_cnt;
    int n_checks;
    logic [31:0] d;

    rcn_top dut (.mclk(mclk), .reset(reset), .pins0(pins[0]),
        .pins1(pins[1]), .meas(meas), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq));

    for (genvar i = 0; i < 2; i++)
    begin : g_fld
        rcn_field fld (.mclk(mclk), .reset(reset), .brk_cmd(brk_cmd[i]),
            .trip_req(trip[i]), .ext_rel(ext_rel[i]), .fuse(fuse[i]),
            .blk(blk[i]), .pins(pins[i]));
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e,
        input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask

    task automatic stat_until(input logic [31:0] m, input logic [31:0] v);
        int i;
        for (i = 0; i < 3000; i++)
        begin
            rd(4'h9);
            if ((d & m) === v)
                break;
        end
        if (i == 3000)
        begin
            error_cnt++;
            $display("ERROR stat wait expected %h seen %h", v, d & m);
            finish_test();
        end
    endtask

    task automatic quiet(input logic [31:0] m);
        repeat (20)
        begin
            rd(4'h9);
            chk("stat quiet", 32'h0, d & m);
        end
    endtask

    task automatic pulse(input logic [5:0] m);
        trip[0] <= m;
        repeat (8) @(posedge mclk);
        trip[0] <= 6'h00;
        @(posedge mclk);
    endtask

    task automatic brk(input int u, input logic v);
        brk_cmd[u] <= v;
        repeat (40) @(posedge mclk);
    endtask

    task automatic t_regs();
        for (int a = 0; a < 12; a++)
        begin
            rd(a[3:0]);
            chk("reset value", 32'h0, d);
        end
        wr(4'hc, 32'h5a5a_a5a5);
        rd(4'hc);
        chk("unmapped", 32'h0, d);
        wr(4'h2, 32'h0f00_0b00);
        wr(4'h3, 32'h0f00_0b00);
        rd(4'h2);
        chk("voltage limits", 32'h0f00_0b00, d);
        wr(4'h4, 32'h021c_01cc);
        wr(4'h5, 32'h021c_01cc);
        wr(4'h6, 32'h0000_0400);
        wr(4'hb, 32'h1);
    endtask

    task automatic t_breaker();
        wr(4'h7, 32'h2);
        wr(4'h0, EN | BRK | CV);
        brk_cmd[0] <= 1'b0;
        stat_until(32'h1, 32'h1);
        chk("irq on trigger", 32'h1, {31'h0, irq});
        rd(4'h9);
        chk("no early permit", 32'h1, d & 32'h5);
        wr(4'hb, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(4'hb, 32'h1);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(4'ha, 32'h3f);
        chk("irq cleared", 32'h0, {31'h0, irq});
        stat_until(32'h4, 32'h4);
        chk("eval cleared at permit", 32'h0, d & 32'h1);
        brk_cmd[0] <= 1'b1;
        stat_until(32'h4, 32'h0);
        rd(4'ha);
        chk("istat permit events", 32'h14, d);
        wr(4'h0, 32'h0);
    endtask

    task automatic t_decouple();
        brk_cmd[0] <= 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            wr(4'h0, EN | (32'h100 << i));
            pulse(6'h01 << ((i + 1) % 6));
            quiet(32'h1);
            pulse(6'h01 << i);
            stat_until(32'h5, 32'h4);
            pulse(6'h01 << i);
            stat_until(32'h4, 32'h0);
            wr(4'h0, 32'h0);
            rd(4'h9);
            chk("disabled unit idle", 32'h0, d & 32'h5);
        end
    endtask

    task automatic t_both();
        wr(4'h0, EN | BRK | 32'h100);
        brk(0, 1'b1);
        brk(0, 1'b0);
        quiet(32'h1);
        brk(0, 1'b1);
        trip[0] <= 6'h01;
        @(posedge mclk);
        brk_cmd[0] <= 1'b0;
        trip[0] <= 6'h00;
        stat_until(32'h1, 32'h1);
        stat_until(32'h5, 32'h4);
        pulse(6'h01);
        stat_until(32'h4, 32'h0);
    endtask

    task automatic t_block();
        wr(4'h0, EN | BRK | FUS);
        blk[0] <= 1'b1;
        brk(0, 1'b1);
        brk(0, 1'b0);
        quiet(32'h5);
        blk[0] <= 1'b0;
        fuse[0] <= 1'b1;
        brk(0, 1'b1);
        brk(0, 1'b0);
        quiet(32'h5);
        brk(0, 1'b1);
        wr(4'h0, EN | BRK);
        brk_cmd[0] <= 1'b0;
        stat_until(32'h1, 32'h1);
        fuse[0] <= 1'b0;
        wr(4'h0, 32'h0);
    endtask

    task automatic t_limits();
        wr(4'h7, 32'h4);
        wr(4'h0, EN | CV | CX);
        meas.voltage <= 16'h0a00;
        stat_until(32'h1, 32'h1);
        meas.voltage <= 16'h0d00;
        repeat (500) @(posedge mclk);
        ext_rel[0] <= 1'b0;
        repeat (20) @(posedge mclk);
        rd(4'h9);
        chk("permit held off", 32'h1, d & 32'h5);
        ext_rel[0] <= 1'b1;
        repeat (500) @(posedge mclk);
        rd(4'h9);
        chk("timer restarted", 32'h1, d & 32'h5);
        stat_until(32'h5, 32'h4);
        meas.voltage <= 16'h1000;
        stat_until(32'h5, 32'h1);
        wr(4'h0, 32'h0);
        meas.voltage <= 16'h0300;
        wr(4'h0, EN | CF);
        stat_until(32'h1, 32'h1);
        repeat (1000) @(posedge mclk);
        rd(4'h9);
        chk("freq check blocked", 32'h1, d & 32'h5);
        meas.voltage <= 16'h0d00;
        stat_until(32'h5, 32'h4);
        meas.freq <= 16'h0100;
        stat_until(32'h5, 32'h1);
        meas.freq <= 16'h01f4;
        wr(4'h0, 32'h0);
        wr(4'h0, EN | BRK | 32'h40);
        rd(4'h9);
        chk("ext fall unit idle", 32'h0, d & 32'h5);
        ext_rel[0] <= 1'b0;
        stat_until(32'h1, 32'h1);
        ext_rel[0] <= 1'b1;
        wr(4'h0, 32'h0);
    endtask

    task automatic t_chain();
        brk(0, 1'b1);
        wr(4'h7, 32'h14);
        wr(4'h8, 32'h2);
        wr(4'h0, EN | BRK);
        wr(4'h1, EN | CV | 32'h1_0000);
        brk_cmd[0] <= 1'b0;
        stat_until(32'h1, 32'h1);
        meas.voltage <= 16'h0a00;
        quiet(32'ha);
        meas.voltage <= 16'h0d00;
        stat_until(32'h5, 32'h4);
        meas.voltage <= 16'h0a00;
        stat_until(32'h2, 32'h2);
        chk("unit0 unaffected", 32'h4, d & 32'h4);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        reset = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        meas.voltage = 16'h0d00;
        meas.freq = 16'h01f4;
        brk_cmd = 2'h3;
        ext_rel = 2'h3;
        fuse = 2'h0;
        blk = 2'h0;
        trip[0] = 6'h00;
        trip[1] = 6'h00;
        error_cnt = 0;
        n_checks = 0;
        d = 32'h0;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        t_regs();
        t_breaker();
        t_decouple();
        t_both();
        t_block();
        t_limits();
        t_chain();
        finish_test();
    end
endmodule
